// >>> host_bfm.sv
// Purpose: Host processor model driving the register port.
// Assumes: Avalon-MM slave answers with waitrequest low.
// Notes: A stalled answer is ended only by the bench timeout.
`timescale 1ns/1ps
module host_bfm
  import rx_path_status_pkg::*;
(
  input wire logic ref_clk_i,
  input wire avl_rsp_t rsp_i,
  output avl_req_t req_o
);
  initial begin
    req_o = '0;
  end
  // The request is held until waitrequest is sampled low at an edge.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk_i);
    req_o.address <= a;
    req_o.write <= w;
    req_o.read <= !w;
    req_o.writedata <= {24'h00_0000, d};
    do begin
      @(posedge ref_clk_i);
    end while (rsp_i.waitrequest !== 1'b0);
    q = rsp_i.readdata[7:0];
    req_o.read <= 1'b0;
    req_o.write <= 1'b0;
  endtask
endmodule // host_bfm

// >>> rx_path_overhead_status_irq.sv
// Purpose: Alarm status, event latches, interrupt and parity error count.
// Assumes: Detector inputs come from pins of another domain.
// Notes: Every access is answered one cycle after it is first seen.
`timescale 1ns/1ps

// How it works
// [RULE1] Status bit reads 1 while pointer loss is present.
// [RULE2] Status bit reads 1 while path alarm indication is present.
// [RULE3] Status bit reads 1 while path far-end fail is present.
// [RULE4] Label change latches an event bit until the latch is read.
// [RULE5] Any pointer loss toggle latches an event bit until read.
// [RULE6] Any path alarm indication change latches an event bit until read.
// [RULE7] Any far-end fail change latches an event bit until read.
// [RULE8] A parity error latches an event bit until read.
// [RULE9] A far-end block error latches an event bit until read.
// [RULE10] Reading the latch register clears all latched bits.
// [RULE11] Interrupt is signalled by driving the request output low.
// [RULE12] Label interrupt needs enable and over two consecutive non-13H bytes.
// [RULE13] Pointer loss change interrupts only when enabled.
// [RULE14] Path alarm indication event interrupts only when enabled.
// [RULE15] Far-end fail change interrupts only when enabled.
// [RULE16] Parity error interrupts only when enabled.
// [RULE17] Far-end block error interrupts only when enabled.
// [RULE18] Label register holds 13H or the first byte that completes a run of three non-13H bytes, kept until reset.
// [RULE19] About 1 us after a trigger write, counter copies to registers.
// [RULE20] The internal counter restarts from zero at each snapshot.
// [RULE21] Count registers give 16-bit count, low byte then high byte. Only the parity count registers do; the far-end count registers read zero.
// [RULE22] Request stays low while any enabled latched bit remains.
// [RULE23] The internal counter saturates rather than wraps.
module rx_path_overhead_status_irq (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire rx_path_status_pkg::avl_req_t avl_req_i,
  output rx_path_status_pkg::avl_rsp_t avl_rsp_o,
  input wire rx_path_status_pkg::path_in_t path_in_i,
  output logic interrupt_request_low_o
);
  import rx_path_status_pkg::*;

  typedef enum logic [0:0] {BUS_IDLE, BUS_DONE} bus_state_t;

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == COUNT_MAX) ? v : v + 16'h0001;
  endfunction

  bus_state_t bus_state;
  path_in_t meta_in;
  path_in_t sync_in;
  path_in_t prev_in;
  logic [7:0] event_latch;
  logic [7:0] event_enable;
  logic [7:0] received_label_value;
  logic [15:0] parity_error_count;
  logic [15:0] parity_acc;
  logic [1:0] label_run;
  logic label_locked;
  logic snap_pending;
  logic [SNAP_CNT_W-1:0] snap_cnt;
  logic [31:0] rdata;
  logic wait_flag;

  wire logic [7:0] idx = avl_req_i.address;
  wire logic req_any = avl_req_i.read | avl_req_i.write;
  wire logic access = req_any && bus_state == BUS_IDLE;
  wire logic rd_take = access && avl_req_i.read;
  wire logic wr_take = access && avl_req_i.write;
  wire logic latch_read = rd_take && idx == IDX_PATH_EVENT_LATCH;
  wire logic snap_trigger = wr_take && (idx == IDX_PARITY_COUNT_LOW ||
    idx == IDX_PARITY_COUNT_HIGH || idx == IDX_FAR_COUNT_LOW ||
    idx == IDX_FAR_COUNT_HIGH || idx == IDX_MASTER_RESET);
  wire logic snap_fire = snap_pending && snap_cnt == SNAP_CNT_W'(1);
  wire logic lbl_new = sync_in.label_valid && !prev_in.label_valid;
  wire logic lbl_odd = lbl_new && sync_in.label_byte != LABEL_DEFAULT;
  wire logic lbl_capture = lbl_odd && !label_locked &&
    label_run == 2'(LABEL_RUN - 1);
  wire logic [7:0] alarm_state = {2'b00, sync_in.pointer_loss_alarm, 1'b0,
    sync_in.path_alarm_indication, sync_in.path_far_fail_alarm, 2'b00};
  wire logic [7:0] new_events = {lbl_capture, 1'b0,
    sync_in.pointer_loss_alarm ^ prev_in.pointer_loss_alarm, 1'b0,
    sync_in.path_alarm_indication ^ prev_in.path_alarm_indication,
    sync_in.path_far_fail_alarm ^ prev_in.path_far_fail_alarm,
    sync_in.parity_error, sync_in.far_block_error};
  // A new event in the clearing cycle survives, so no event is lost.
  // [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] [RULE9]
  wire logic [7:0] next_latch = ((latch_read ? 8'h00 : event_latch) |
    new_events) & EVENT_MASK; // [RULE10]
  // [RULE13] [RULE14] [RULE15] [RULE16] [RULE17]
  wire logic irq_any = |(event_latch & event_enable); // [RULE22]
  wire logic [31:0] next_rdata =
    idx == IDX_PATH_ALARM_STATE ? {24'h0000_00, alarm_state} : // [RULE1] [RULE2] [RULE3]
    idx == IDX_PATH_EVENT_LATCH ? {24'h0000_00, event_latch} :
    idx == IDX_PATH_EVENT_ENABLE ? {24'h0000_00, event_enable} :
    idx == IDX_RECEIVED_LABEL ? {24'h0000_00, received_label_value} :
    idx == IDX_PARITY_COUNT_LOW ? {24'h0000_00, parity_error_count[7:0]} : // [RULE21]
    idx == IDX_PARITY_COUNT_HIGH ? {24'h0000_00, parity_error_count[15:8]} :
    32'h0000_0000;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_in <= '0;
      sync_in <= '0;
      prev_in <= '0;
    end else begin
      meta_in <= path_in_i;
      sync_in <= meta_in;
      prev_in <= sync_in;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_state <= BUS_IDLE;
      wait_flag <= 1'b1;
      rdata <= 32'h0000_0000;
    end else begin
      case (bus_state)
        BUS_IDLE: if (req_any) begin
          bus_state <= BUS_DONE;
          wait_flag <= 1'b0;
          rdata <= avl_req_i.read ? next_rdata : 32'h0000_0000;
        end
        BUS_DONE: begin
          bus_state <= BUS_IDLE;
          wait_flag <= 1'b1;
        end
        default: begin
          bus_state <= BUS_IDLE;
          wait_flag <= 1'b1;
        end
      endcase
    end
  end

  assign avl_rsp_o.readdata = rdata;
  assign avl_rsp_o.waitrequest = wait_flag;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      event_latch <= 8'h00;
      event_enable <= ENABLE_RESET;
      interrupt_request_low_o <= 1'b1;
    end else begin
      event_latch <= next_latch;
      if (wr_take && idx == IDX_PATH_EVENT_ENABLE)
        event_enable <= avl_req_i.writedata[7:0] & EVENT_MASK;
      interrupt_request_low_o <= !irq_any; // [RULE11] [RULE22]
    end
  end

  // Label events only count after a run of mismatches, which filters noise.
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      label_run <= 2'b00;
      label_locked <= 1'b0;
      received_label_value <= LABEL_DEFAULT;
    end else if (lbl_new) begin
      if (!lbl_odd) begin
        label_run <= 2'b00;
      end else if (label_run != 2'(LABEL_RUN - 1)) begin
        label_run <= label_run + 2'b01; // [RULE12]
      end
      if (lbl_capture) begin
        label_locked <= 1'b1;
        received_label_value <= sync_in.label_byte; // [RULE18]
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      snap_pending <= 1'b0;
      snap_cnt <= '0;
      parity_acc <= COUNT_RESET;
      parity_error_count <= COUNT_RESET;
    end else begin
      if (snap_trigger) begin
        snap_pending <= 1'b1;
        snap_cnt <= SNAP_CNT_W'(SNAP_CYCLES); // [RULE19]
      end else if (snap_pending) begin
        snap_cnt <= snap_cnt - SNAP_CNT_W'(1);
        if (snap_fire)
          snap_pending <= 1'b0;
      end
      if (snap_fire) begin
        parity_error_count <= parity_acc; // [RULE19] [RULE21]
        parity_acc <= sync_in.parity_error ? 16'h0001 : COUNT_RESET; // [RULE20]
      end else if (sync_in.parity_error) begin
        parity_acc <= sat_inc(parity_acc); // [RULE23]
      end
    end
  end

  chk_latch_read_clears: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) latch_read && new_events == 8'h00
    |=> event_latch == 8'h00) else $error("latch not cleared by read"); // [RULE10]
  chk_pointer_toggle_latch: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) $changed(sync_in.pointer_loss_alarm)
    |=> event_latch[BIT_POINTER]) else $error("pointer toggle lost"); // [RULE5]
  chk_parity_latch: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) sync_in.parity_error
    |=> event_latch[BIT_PARITY]) else $error("parity event lost"); // [RULE8]
  chk_irq_follows_pair: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) |(event_latch & event_enable)
    |=> !interrupt_request_low_o) else $error("irq not asserted"); // [RULE22]
  chk_irq_masked_off: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) (event_latch & event_enable) == 8'h00
    |=> interrupt_request_low_o) else $error("irq without source"); // [RULE11]
  chk_snapshot_delay: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) snap_trigger ##1 (!snap_trigger)[*8]
    |-> snap_pending) else $error("snapshot too early"); // [RULE19]
  chk_acc_restart: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) snap_fire && !sync_in.parity_error
    |=> parity_acc == COUNT_RESET) else $error("counter not restarted"); // [RULE20]
  chk_acc_saturates: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) parity_acc == COUNT_MAX && !snap_fire
    |=> parity_acc == COUNT_MAX) else $error("counter wrapped"); // [RULE23]
  chk_label_held: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) label_locked && $past(label_locked)
    |-> $stable(received_label_value)) else $error("label changed"); // [RULE18]
  chk_status_reads_alarm: assert property (@(posedge ref_clk_i)
    disable iff (!rstn_i) rd_take && idx == IDX_PATH_ALARM_STATE
    |=> rdata[BIT_POINTER] == $past(sync_in.pointer_loss_alarm))
    else $error("status read wrong"); // [RULE1]

  cov_latch_read: cover property (@(posedge ref_clk_i) latch_read);
  cov_snapshot: cover property (@(posedge ref_clk_i) snap_fire);
  cov_label_capture: cover property (@(posedge ref_clk_i) lbl_capture);
  cov_irq_low: cover property (@(posedge ref_clk_i) !interrupt_request_low_o);
endmodule // rx_path_overhead_status_irq

// >>> rx_path_status_pkg.sv
// Purpose: Shared constants and types of the receive path status block.
// Assumes: Avalon-MM slave with 32-bit data, one register per aligned word.
// Notes: Register byte address is four times the register index.
package rx_path_status_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] IDX_PATH_ALARM_STATE = 8'h30;
  localparam logic [7:0] IDX_PATH_EVENT_LATCH = 8'h31;
  localparam logic [7:0] IDX_PATH_EVENT_ENABLE = 8'h33;
  localparam logic [7:0] IDX_RECEIVED_LABEL = 8'h37;
  localparam logic [7:0] IDX_PARITY_COUNT_LOW = 8'h38;
  localparam logic [7:0] IDX_PARITY_COUNT_HIGH = 8'h39;
  localparam logic [7:0] IDX_FAR_COUNT_LOW = 8'h3A;
  localparam logic [7:0] IDX_FAR_COUNT_HIGH = 8'h3B;
  localparam logic [7:0] IDX_MASTER_RESET = 8'h00;
  // Bit positions shared by the latch and enable registers.
  localparam int BIT_LABEL = 7;
  localparam int BIT_POINTER = 5;
  localparam int BIT_AIS = 3;
  localparam int BIT_FAR_FAIL = 2;
  localparam int BIT_PARITY = 1;
  localparam int BIT_FAR_BLOCK = 0;
  localparam logic [7:0] EVENT_MASK = 8'hAF;
  localparam logic [7:0] ALARM_MASK = 8'h2C;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] LABEL_DEFAULT = 8'h13;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam int LABEL_RUN = 3;
  localparam int CLK_MHZ = 200;
  localparam int SNAP_DELAY_NS = 1000;
  localparam int SNAP_CYCLES = (SNAP_DELAY_NS * CLK_MHZ) / 1000;
  localparam int SNAP_CNT_W = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } avl_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avl_rsp_t;

  typedef struct packed {
    logic pointer_loss_alarm;
    logic path_alarm_indication;
    logic path_far_fail_alarm;
    logic label_valid;
    logic [7:0] label_byte;
    logic parity_error;
    logic far_block_error;
  } path_in_t;
endpackage

// >>> tb.sv
// Purpose: Self-checking bench of the receive path status block.
// Assumes: Snapshot lands 200 cycles after the trigger write.
// Notes: Counter saturation is not reached; it would take too long.
`timescale 1ns/1ps
module tb;
  import rx_path_status_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  avl_req_t req;
  avl_rsp_t rsp;
  path_in_t pin;
  logic irq_n;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int exp_par = 0;
  logic [31:0] rs = 32'h0000_0016;
  logic [7:0] q, en, st, chg, prev, lb;
  int n;
  always #2.5 ref_clk_i = ~ref_clk_i;
  rx_path_overhead_status_irq rx_path_overhead_status_irq_i (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .avl_req_i(req),
    .avl_rsp_o(rsp), .path_in_i(pin), .interrupt_request_low_o(irq_n));
  host_bfm host_bfm_i (.ref_clk_i(ref_clk_i), .rsp_i(rsp), .req_o(req));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [15:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, e, input string what);
    host_bfm_i.xfer(1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e}, what);
  endtask
  task automatic wr(input logic [7:0] a, d);
    host_bfm_i.xfer(1'b1, a, d, q);
  endtask
  task automatic pulse(input logic far);
    @(posedge ref_clk_i);
    if (far) pin.far_block_error <= 1'b1;
    else begin
      pin.parity_error <= 1'b1;
      exp_par++;
    end
    @(posedge ref_clk_i);
    pin.far_block_error <= 1'b0;
    pin.parity_error <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic lbl(input logic [7:0] b);
    @(posedge ref_clk_i);
    pin.label_byte <= b;
    pin.label_valid <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    pin.label_valid <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // A hang counts as a mismatch and ends the run.
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    pin = '0;
    pin.label_byte = LABEL_DEFAULT;
    prev = 8'h00;
    repeat (10) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd(IDX_PATH_EVENT_ENABLE, ENABLE_RESET, "enable");
    rd(IDX_RECEIVED_LABEL, LABEL_DEFAULT, "label");
    rd(IDX_PARITY_COUNT_LOW, 8'h00, "count low");
    rd(IDX_PARITY_COUNT_HIGH, 8'h00, "count high");
    rd(8'h20, 8'h00, "unmapped");
    chk(16'(irq_n), 16'h0001, "irq idle");
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      rs = xs(rs);
      en = rs[15:8] & ALARM_MASK;
      wr(IDX_PATH_EVENT_ENABLE, en);
      rd(IDX_PATH_EVENT_ENABLE, en, "enable rw");
      @(posedge ref_clk_i);
      pin.pointer_loss_alarm <= rs[0];
      pin.path_alarm_indication <= rs[1];
      pin.path_far_fail_alarm <= rs[2];
      repeat (6) @(posedge ref_clk_i);
      st = {2'b00, rs[0], 1'b0, rs[1], rs[2], 2'b00};
      chg = st ^ prev;
      prev = st;
      chk(16'(irq_n), 16'(!(|(chg & en))), "irq");
      rd(IDX_PATH_ALARM_STATE, st, "alarm");
      rd(IDX_PATH_EVENT_LATCH, chg, "latch");
      rd(IDX_PATH_EVENT_LATCH, 8'h00, "latch clr");
      chk(16'(irq_n), 16'h0001, "irq clr");
    end
    $display("alarm test done");
    wr(IDX_PATH_EVENT_ENABLE, 8'h02);
    n = int'(rs[4:0]) + 1;
    for (int i = 0; i < n; i++) pulse(1'b0);
    pulse(1'b1);
    repeat (6) @(posedge ref_clk_i);
    chk(16'(irq_n), 16'h0000, "irq parity");
    rd(IDX_PATH_EVENT_LATCH, 8'h03, "err latch");
    wr(IDX_PARITY_COUNT_LOW, 8'h00);
    repeat (205) @(posedge ref_clk_i);
    rd(IDX_PARITY_COUNT_LOW, exp_par[7:0], "count low");
    rd(IDX_PARITY_COUNT_HIGH, exp_par[15:8], "count high");
    exp_par = 0;
    wr(IDX_MASTER_RESET, 8'h00);
    repeat (205) @(posedge ref_clk_i);
    rd(IDX_PARITY_COUNT_LOW, exp_par[7:0], "count zero");
    wr(IDX_PATH_EVENT_ENABLE, 8'h01);
    pulse(1'b1);
    repeat (6) @(posedge ref_clk_i);
    chk(16'(irq_n), 16'h0000, "irq far");
    rd(IDX_PATH_EVENT_LATCH, 8'h01, "far latch");
    $display("error test done");
    wr(IDX_PATH_EVENT_ENABLE, 8'h80);
    lb = rs[15:8] | 8'h80;
    lbl(LABEL_DEFAULT);
    lbl(lb);
    lbl(lb);
    chk(16'(irq_n), 16'h0001, "irq two");
    lbl(lb);
    repeat (6) @(posedge ref_clk_i);
    chk(16'(irq_n), 16'h0000, "irq label");
    rd(IDX_RECEIVED_LABEL, lb, "label");
    rd(IDX_PATH_EVENT_LATCH, 8'h80, "label latch");
    for (int i = 0; i < 3; i++) lbl(8'h66);
    rd(IDX_RECEIVED_LABEL, lb, "label kept");
    $display("label test done");
    wrap_up();
  end
endmodule // tb
